// ===== rtl/cfg_integrity_map.vh
// Constants for the configuration integrity and test-port enable block.
// Assumes a 100 MHz system clock and a 64-word data flash with ECC.
`ifndef CFG_INTEGRITY_MAP_VH
`define CFG_INTEGRITY_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// Data flash geometry and region layout
`define FL_AW        6
`define FL_DEPTH     64
`define FL_DW        32
`define FL_CW        6
`define FL_WW        38
`define FW_LAST      6'h0f
`define CFG_FIRST    6'h10
`define CFG_LAST     6'h2f
`define LOG_LAST     6'h3f
`define ERASED_WORD  38'h3f_ffff_ffff
`define ERASED_DATA  32'hffff_ffff

////////////////////////////////////////////////////////////////////////////////
// Bus command and address
`define SOFT_RST_CODE 8'hdb
`define TAP_ADDR      7'h7e

////////////////////////////////////////////////////////////////////////////////
// Watchdog timing
`define CLK_MHZ        100
`define WDT_TIMEOUT_US 1000
`define WDT_CYCLES     17'h186a0
`define WDT_W          17

////////////////////////////////////////////////////////////////////////////////
// Test-access port instructions
`define IR_W        4
`define IR_CAPTURE  4'h1
`define IR_PROG     4'h8
`define IR_ADDR     4'h9
`define IR_BYPASS   4'hf

`endif

// ===== rtl/flash_store.v
// Data flash array: one write port, one read port with registered data.
// Assumes the caller arbitrates the write port and supplies ECC bits.
`timescale 1ns/1ps
`include "cfg_integrity_map.vh"

module flash_store (
  input  wire                i_sys_clk,
  input  wire                i_wr_en,
  input  wire [`FL_AW-1:0]   i_wr_addr,
  input  wire [`FL_WW-1:0]   i_wr_data,
  input  wire [`FL_AW-1:0]   i_rd_addr,
  output reg  [`FL_WW-1:0]   o_rd_data
);

  reg [`FL_WW-1:0] mem [0:`FL_DEPTH-1];

  // No reset on the array: contents persist like flash
  always @(posedge i_sys_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= mem[i_rd_addr];
  end

endmodule // flash_store

// ===== rtl/cfg_integrity_jtag_en.v
// Power-up integrity checks, in-service flash update and test-port enable.
// Assumes bus decoding, clock generation and PWM live outside this block.
//
// Notes on behaviour
// R1 - Host: unprotect, erase, write image, reset
// R2 - After rewrite keep old config, logging off
// R3 - Test port off by default; pins are GPIO
// R4 - Four of six port pins usable as GPIO
// R5 - Blank flash at power-up enables test port
// R6 - Bus address 126 at power-up enables port
// R7 - Clock slows to 90% while port enabled
// R8 - Standard TAP protocol, no boundary scan
// R9 - Bad firmware checksum: idle, bus commands only
// R10 - Bad config checksum: load factory default
// R11 - Default fallback asserts alert and status flag
// R12 - Error-log region checked by own checksum
// R13 - Watchdog timeout restarts device initialisation
// R14 - In reset: GPIO released, fast pulse low
// R15 - Every parameter range checked before acceptance
// R16 - Six ECC bits generated per written word
// R17 - Single-bit flash errors corrected on read
// R18 - Send-byte 0xdb restarts initialisation, self-clearing
// R19 - Hamming syndrome selects the bit to flip
`timescale 1ns/1ps
`include "cfg_integrity_map.vh"

module cfg_integrity_jtag_en #(
  parameter [`WDT_W-1:0] WDT_CYCLES = `WDT_CYCLES
) (
  input  wire                i_sys_clk,
  input  wire                i_rst,
  input  wire [6:0]          i_bus_addr,
  input  wire                i_cmd_vld,
  input  wire [7:0]          i_cmd_code,
  input  wire                i_wp_off,
  input  wire                i_erase,
  input  wire                i_wr_en,
  input  wire [`FL_AW-1:0]   i_wr_addr,
  input  wire [`FL_DW-1:0]   i_wr_data,
  input  wire                i_param_vld,
  input  wire [15:0]         i_param_val,
  input  wire [15:0]         i_param_min,
  input  wire [15:0]         i_param_max,
  input  wire                i_wdt_kick,
  input  wire                i_fast_pulse,
  input  wire [3:0]          i_gpio_i,
  input  wire [3:0]          i_gpio_o,
  input  wire [3:0]          i_gpio_drv,
  output wire [3:0]          o_gpio_o,
  output wire [3:0]          o_gpio_oe_n,
  output reg  [3:0]          o_gpio_i,
  output reg                 o_fast_pulse_pin,
  output reg                 o_in_reset,
  output reg                 o_fw_run,
  output reg                 o_fw_bad,
  output reg                 o_cfg_dflt,
  output reg                 o_bus_alert_out_n,
  output reg                 o_log_bad,
  output reg                 o_jtag_en,
  output reg                 o_clk_slow,
  output reg                 o_fault_log_en,
  output reg                 o_busy,
  output reg                 o_ecc_fixed,
  output reg                 o_param_ok,
  output reg                 o_param_err
);

  localparam [3:0] ST_INIT = 4'h1;
  localparam [3:0] ST_SCAN = 4'h2;
  localparam [3:0] ST_RUN  = 4'h4;
  localparam [3:0] ST_HALT = 4'h8;

  localparam [15:0] T_TLR = 16'h0001, T_RTI = 16'h0002, T_SDS = 16'h0004, T_CDR = 16'h0008;
  localparam [15:0] T_SDR = 16'h0010, T_E1D = 16'h0020, T_PDR = 16'h0040, T_E2D = 16'h0080;
  localparam [15:0] T_UDR = 16'h0100, T_SIS = 16'h0200, T_CIR = 16'h0400, T_SIR = 16'h0800;
  localparam [15:0] T_E1I = 16'h1000, T_PIR = 16'h2000, T_E2I = 16'h4000, T_UIR = 16'h8000;

  localparam [`WDT_W-1:0] WDT_LAST = WDT_CYCLES - 17'h00001;

  ////////////////////////////////////////////////////////////////////////////
  // Hamming code: check bits are the XOR of positions of set data bits

  function [`FL_CW-1:0] ecc_gen;
    input [`FL_DW-1:0] d;
    integer p, j;
    begin
      ecc_gen = 6'h00;
      j = 0;
      for (p = 1; p < 39; p = p + 1) begin
        if ((p & (p - 1)) != 0) begin
          if (d[j]) ecc_gen = ecc_gen ^ p[5:0];
          j = j + 1;
        end
      end
    end
  endfunction

  function [`FL_DW-1:0] ecc_fix;
    input [`FL_DW-1:0] d;
    input [`FL_CW-1:0] s;
    integer p, j;
    begin
      ecc_fix = d;
      j = 0;
      for (p = 1; p < 39; p = p + 1) begin
        if ((p & (p - 1)) != 0) begin
          if (s == p[5:0]) ecc_fix[j] = ~d[j];
          j = j + 1;
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State and storage

  reg  [3:0]          st_ff;
  reg                 issue_ff, dat_vld_ff;
  reg  [`FL_AW-1:0]   rd_addr_ff, dat_addr_ff;
  reg  [`FL_DW-1:0]   sum_ff;
  reg                 fw_bad_ff, cfg_bad_ff, log_bad_ff, blank_ff;
  reg                 jtag_en_ff, wp_off_ff, upd_pend_ff;
  reg  [`WDT_W-1:0]   wdt_cnt_ff;
  reg                 erase_busy_ff;
  reg  [`FL_AW-1:0]   eaddr_ff;
  reg  [15:0]         tap_ff, nxt_tap;
  reg  [2:0]          tap_in_ff;
  reg                 tck_prev_ff, tdo_ff, jwr_ff;
  reg  [`IR_W-1:0]    ir_ff, ir_sh_ff;
  reg  [`FL_DW-1:0]   dr_sh_ff, jwr_data_ff;
  reg  [`FL_AW-1:0]   jaddr_ff, jwr_addr_ff;

  wire [`FL_WW-1:0]   rd_raw;
  wire                st_run  = (st_ff == ST_RUN);
  wire                st_halt = (st_ff == ST_HALT);
  wire                live    = st_run | st_halt;
  wire [`FL_CW-1:0]   syn     = ecc_gen(rd_raw[`FL_DW-1:0]) ^ rd_raw[`FL_WW-1:`FL_DW];
  wire [`FL_DW-1:0]   rd_word = ecc_fix(rd_raw[`FL_DW-1:0], syn);   // R17 R19
  wire                raw_ones = (rd_raw == `ERASED_WORD);
  wire                sum_ok  = (sum_ff == rd_word);
  wire                soft_rst = i_cmd_vld & (i_cmd_code == `SOFT_RST_CODE);
  wire                wdt_exp = st_run & (wdt_cnt_ff == WDT_LAST);
  wire                erase_go = i_erase & wp_off_ff & ~erase_busy_ff & live;
  wire                hwr_ok  = i_wr_en & wp_off_ff & ~erase_busy_ff & ~jwr_ff & live;
  wire                fl_we   = erase_busy_ff | jwr_ff | hwr_ok;
  wire [`FL_AW-1:0]   fl_waddr = erase_busy_ff ? eaddr_ff : (jwr_ff ? jwr_addr_ff : i_wr_addr);
  wire [`FL_DW-1:0]   wdat    = jwr_ff ? jwr_data_ff : i_wr_data;
  wire [`FL_WW-1:0]   fl_wdata = erase_busy_ff ? `ERASED_WORD : {ecc_gen(wdat), wdat};   // R16
  wire                tck_rise = jtag_en_ff & tap_in_ff[0] & ~tck_prev_ff;
  wire                tck_fall = jtag_en_ff & ~tap_in_ff[0] & tck_prev_ff;
  wire                tms = tap_in_ff[1];
  wire                tdi = tap_in_ff[2];

  flash_store u_flash (
    .i_sys_clk (i_sys_clk),
    .i_wr_en   (fl_we),
    .i_wr_addr (fl_waddr),
    .i_wr_data (fl_wdata),
    .i_rd_addr (rd_addr_ff),
    .o_rd_data (rd_raw)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Power-up scan and operating state

  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_ff       <= ST_INIT;
      issue_ff    <= 1'b0;
      dat_vld_ff  <= 1'b0;
      rd_addr_ff  <= 6'h00;
      dat_addr_ff <= 6'h00;
      sum_ff      <= 32'h0000_0000;
      fw_bad_ff   <= 1'b0;
      cfg_bad_ff  <= 1'b0;
      log_bad_ff  <= 1'b0;
      blank_ff    <= 1'b1;
      jtag_en_ff  <= 1'b0;                                  // R3
      wp_off_ff   <= 1'b0;
      upd_pend_ff <= 1'b0;
    end else begin
      dat_vld_ff  <= issue_ff & (st_ff == ST_SCAN);
      dat_addr_ff <= rd_addr_ff;
      case (st_ff)
        ST_INIT: begin
          issue_ff    <= 1'b1;
          rd_addr_ff  <= 6'h00;
          sum_ff      <= 32'h0000_0000;
          fw_bad_ff   <= 1'b0;
          cfg_bad_ff  <= 1'b0;
          log_bad_ff  <= 1'b0;
          blank_ff    <= 1'b1;
          jtag_en_ff  <= 1'b0;
          wp_off_ff   <= 1'b0;
          upd_pend_ff <= 1'b0;
          st_ff       <= ST_SCAN;
        end
        ST_SCAN: begin
          if (issue_ff) begin
            rd_addr_ff <= rd_addr_ff + 6'h01;
            if (rd_addr_ff == `LOG_LAST) issue_ff <= 1'b0;
          end
          if (dat_vld_ff) begin
            if (dat_addr_ff >= `CFG_FIRST && !raw_ones) blank_ff <= 1'b0;
            if (dat_addr_ff == `FW_LAST || dat_addr_ff == `CFG_LAST || dat_addr_ff == `LOG_LAST) begin
              sum_ff <= 32'h0000_0000;
              if (dat_addr_ff == `FW_LAST) fw_bad_ff <= ~sum_ok;      // R9
              if (dat_addr_ff == `CFG_LAST) cfg_bad_ff <= ~sum_ok;    // R10
              if (dat_addr_ff == `LOG_LAST) log_bad_ff <= ~sum_ok;    // R12
            end else begin
              sum_ff <= sum_ff + rd_word;
            end
            if (dat_addr_ff == `LOG_LAST) begin
              st_ff      <= fw_bad_ff ? ST_HALT : ST_RUN;             // R9
              jtag_en_ff <= (blank_ff & raw_ones)                     // R5
                          | (i_bus_addr == `TAP_ADDR);                // R6
            end
          end
        end
        default: begin
          // The write-protect release and the pending-update mark live until reset
          if (i_wp_off) wp_off_ff <= 1'b1;
          if (st_run & (erase_go | hwr_ok | jwr_ff)) upd_pend_ff <= 1'b1;  // R2
        end
      endcase
      if (soft_rst | wdt_exp) st_ff <= ST_INIT;             // R18 R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Firmware watchdog: counts only while firmware runs

  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wdt_cnt_ff <= 17'h00000;
    end else if (!st_run || i_wdt_kick || wdt_exp) begin
      wdt_cnt_ff <= 17'h00000;
    end else begin
      wdt_cnt_ff <= wdt_cnt_ff + 17'h00001;                 // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Erase sequencer: one word per cycle, bus writes refused meanwhile

  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      erase_busy_ff <= 1'b0;
      eaddr_ff      <= 6'h00;
    end else if (erase_go) begin
      erase_busy_ff <= 1'b1;                                // R1
      eaddr_ff      <= 6'h00;
    end else if (erase_busy_ff) begin
      eaddr_ff <= eaddr_ff + 6'h01;
      if (eaddr_ff == `LOG_LAST) erase_busy_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test-access port, sampled from the shared pins; no boundary register

  always @* begin
    case (tap_ff)
      T_TLR:   nxt_tap = tms ? T_TLR : T_RTI;               // R8
      T_RTI:   nxt_tap = tms ? T_SDS : T_RTI;
      T_SDS:   nxt_tap = tms ? T_SIS : T_CDR;
      T_CDR:   nxt_tap = tms ? T_E1D : T_SDR;
      T_SDR:   nxt_tap = tms ? T_E1D : T_SDR;
      T_E1D:   nxt_tap = tms ? T_UDR : T_PDR;
      T_PDR:   nxt_tap = tms ? T_E2D : T_PDR;
      T_E2D:   nxt_tap = tms ? T_UDR : T_SDR;
      T_UDR:   nxt_tap = tms ? T_SDS : T_RTI;
      T_SIS:   nxt_tap = tms ? T_TLR : T_CIR;
      T_CIR:   nxt_tap = tms ? T_E1I : T_SIR;
      T_SIR:   nxt_tap = tms ? T_E1I : T_SIR;
      T_E1I:   nxt_tap = tms ? T_UIR : T_PIR;
      T_PIR:   nxt_tap = tms ? T_E2I : T_PIR;
      T_E2I:   nxt_tap = tms ? T_UIR : T_SIR;
      T_UIR:   nxt_tap = tms ? T_SDS : T_RTI;
      default: nxt_tap = T_TLR;
    endcase
  end

  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      tap_ff      <= T_TLR;
      tap_in_ff   <= 3'h0;
      tck_prev_ff <= 1'b0;
      tdo_ff      <= 1'b0;
      ir_ff       <= `IR_BYPASS;
      ir_sh_ff    <= 4'h0;
      dr_sh_ff    <= 32'h0000_0000;
      jaddr_ff    <= 6'h00;
      jwr_ff      <= 1'b0;
      jwr_addr_ff <= 6'h00;
      jwr_data_ff <= 32'h0000_0000;
    end else begin
      tap_in_ff   <= i_gpio_i[2:0];
      tck_prev_ff <= tap_in_ff[0];
      jwr_ff      <= 1'b0;
      if (!jtag_en_ff) begin
        tap_ff <= T_TLR;
        ir_ff  <= `IR_BYPASS;
      end else if (tck_rise) begin
        tap_ff <= nxt_tap;
        if (tap_ff == T_TLR) ir_ff <= `IR_BYPASS;
        if (tap_ff == T_CIR) ir_sh_ff <= `IR_CAPTURE;
        if (tap_ff == T_SIR) ir_sh_ff <= {tdi, ir_sh_ff[3:1]};
        if (tap_ff == T_CDR) dr_sh_ff <= (ir_ff == `IR_ADDR) ? {26'h0, jaddr_ff} : 32'h0000_0000;
        if (tap_ff == T_SDR) begin
          if (ir_ff == `IR_PROG) dr_sh_ff <= {tdi, dr_sh_ff[31:1]};
          else if (ir_ff == `IR_ADDR) dr_sh_ff <= {26'h0, tdi, dr_sh_ff[5:1]};
          else dr_sh_ff <= {31'h0, tdi};
        end
      end else if (tck_fall) begin
        // Shift-out and updates happen on the falling edge
        if (tap_ff == T_SIR) tdo_ff <= ir_sh_ff[0];
        if (tap_ff == T_SDR) tdo_ff <= dr_sh_ff[0];
        if (tap_ff == T_UIR) ir_ff <= ir_sh_ff;
        if (tap_ff == T_UDR && ir_ff == `IR_ADDR) jaddr_ff <= dr_sh_ff[5:0];
        if (tap_ff == T_UDR && ir_ff == `IR_PROG && !erase_busy_ff) begin
          jwr_ff      <= 1'b1;
          jwr_addr_ff <= jaddr_ff;
          jwr_data_ff <= dr_sh_ff;
          jaddr_ff    <= jaddr_ff + 6'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared pins: pin 3 carries test data out, pins 0..2 are port inputs

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_pin
      reg po_ff;
      reg poe_n_ff;
      always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
          po_ff    <= 1'b0;
          poe_n_ff <= 1'b1;
        end else if (!live) begin
          po_ff    <= 1'b0;                                 // R14
          poe_n_ff <= 1'b1;
        end else if (jtag_en_ff) begin
          po_ff    <= (g == 3) ? tdo_ff : 1'b0;
          poe_n_ff <= (g == 3) ? 1'b0 : 1'b1;
        end else begin
          po_ff    <= i_gpio_o[g];                          // R4
          poe_n_ff <= ~i_gpio_drv[g];
        end
      end
      assign o_gpio_o[g]    = po_ff;
      assign o_gpio_oe_n[g] = poe_n_ff;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs

  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_gpio_i          <= 4'h0;
      o_fast_pulse_pin  <= 1'b0;
      o_in_reset        <= 1'b1;
      o_fw_run          <= 1'b0;
      o_fw_bad          <= 1'b0;
      o_cfg_dflt        <= 1'b0;
      o_bus_alert_out_n <= 1'b1;
      o_log_bad         <= 1'b0;
      o_jtag_en         <= 1'b0;
      o_clk_slow        <= 1'b0;
      o_fault_log_en    <= 1'b0;
      o_busy            <= 1'b0;
      o_ecc_fixed       <= 1'b0;
      o_param_ok        <= 1'b0;
      o_param_err       <= 1'b0;
    end else begin
      o_gpio_i          <= (jtag_en_ff || !live) ? 4'h0 : i_gpio_i;   // R3
      o_fast_pulse_pin  <= st_run & i_fast_pulse;                     // R14
      o_in_reset        <= ~live;
      o_fw_run          <= st_run;
      o_fw_bad          <= st_halt & fw_bad_ff;
      o_cfg_dflt        <= live & cfg_bad_ff;                         // R11
      o_bus_alert_out_n <= ~(live & cfg_bad_ff);                      // R11
      o_log_bad         <= live & log_bad_ff;
      o_jtag_en         <= jtag_en_ff;
      o_clk_slow        <= jtag_en_ff;                                // R7
      o_fault_log_en    <= st_run & ~upd_pend_ff;                     // R2
      o_busy            <= erase_busy_ff;
      o_ecc_fixed       <= dat_vld_ff & (syn != 6'h00);
      // Bounds are inclusive
      o_param_ok        <= i_param_vld & (i_param_val >= i_param_min) & (i_param_val <= i_param_max);  // R15
      o_param_err       <= i_param_vld & ((i_param_val < i_param_min) | (i_param_val > i_param_max));  // R15
    end
  end

endmodule // cfg_integrity_jtag_en

// ===== verif/cfg_integrity_chk.sv
// Assertion checker for cfg_integrity_jtag_en, bound to its top ports.
// Assumes a short WDT_CYCLES so the watchdog bound stays small.
`timescale 1ns/1ps
module cfg_integrity_chk #(
  parameter int WDT_CYCLES = 50
) (
  input wire        i_sys_clk,
  input wire        i_rst,
  input wire        i_cmd_vld,
  input wire [7:0]  i_cmd_code,
  input wire        i_param_vld,
  input wire [15:0] i_param_val,
  input wire [15:0] i_param_min,
  input wire [15:0] i_param_max,
  input wire        i_wdt_kick,
  input wire [3:0]  o_gpio_oe_n,
  input wire [3:0]  o_gpio_i,
  input wire        o_fast_pulse_pin,
  input wire        o_in_reset,
  input wire        o_fw_run,
  input wire        o_fw_bad,
  input wire        o_cfg_dflt,
  input wire        o_bus_alert_out_n,
  input wire        o_jtag_en,
  input wire        o_clk_slow,
  input wire        o_fault_log_en,
  input wire        o_busy,
  input wire        o_param_ok,
  input wire        o_param_err
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic in_rng;
  int   idle_cnt_ff;
  assign in_rng = (i_param_val >= i_param_min) && (i_param_val <= i_param_max);
  // Cycles spent running without a kick
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      idle_cnt_ff <= 0;
    end else begin
      idle_cnt_ff <= (o_fw_run && !i_wdt_kick) ? idle_cnt_ff + 1 : 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_param_ok; i_param_vld && in_rng && !o_in_reset |=> o_param_ok && !o_param_err; endproperty
  a_param_ok: assert property (p_param_ok) else $error("range accept");
  property p_param_err; i_param_vld && !in_rng && !o_in_reset |=> o_param_err && !o_param_ok; endproperty
  a_param_err: assert property (p_param_err) else $error("range refuse");
  property p_soft_rst; i_cmd_vld && i_cmd_code == 8'hdb |=> ##1 o_in_reset; endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset");
  property p_wdt; idle_cnt_ff <= WDT_CYCLES + 4; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog late");
  property p_rst_pins; o_in_reset && $past(o_in_reset) |-> o_gpio_oe_n == 4'hf && !o_fast_pulse_pin; endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("reset pins");
  property p_slow; $stable(o_jtag_en) |-> o_clk_slow == o_jtag_en; endproperty
  a_slow: assert property (p_slow) else $error("slow clock");
  property p_tap_pins; o_jtag_en && $past(o_jtag_en) |-> o_gpio_i == 4'h0; endproperty
  a_tap_pins: assert property (p_tap_pins) else $error("test pins");
  property p_alert; $stable(o_cfg_dflt) |-> o_bus_alert_out_n == !o_cfg_dflt; endproperty
  a_alert: assert property (p_alert) else $error("alert");
  property p_fw; !(o_fw_run && o_fw_bad); endproperty
  a_fw: assert property (p_fw) else $error("bad firmware");
  property p_log_off; o_fault_log_en |-> o_fw_run; endproperty
  a_log_off: assert property (p_log_off) else $error("logging");
  property p_erase; $rose(o_busy) |-> ##63 o_busy ##1 !o_busy; endproperty
  a_erase: assert property (p_erase) else $error("erase length");
endmodule  // cfg_integrity_chk

bind cfg_integrity_jtag_en cfg_integrity_chk #(.WDT_CYCLES(WDT_CYCLES)) u_chk (.*);

// ===== verif/jtag_prog_model.sv
// Programmer model on the shared test pins.
// Assumes the block samples its pins on the system clock.
`timescale 1ns/1ps
module jtag_prog_model (
  input  wire  i_sys_clk,
  input  wire  i_tdo,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi
);
  logic [31:0] cap_bits;
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
    cap_bits = 32'h0;
  end
  // Levels held 4 clocks; the block needs 3
  task automatic tck_bit(input logic tms, input logic tdi);
    @(posedge i_sys_clk);
    #1;
    o_tck = 1'b0;
    o_tms = tms;
    o_tdi = tdi;
    repeat (4) @(posedge i_sys_clk);
    #1;
    cap_bits = {i_tdo, cap_bits[31:1]};
    o_tck = 1'b1;
    repeat (3) @(posedge i_sys_clk);
  endtask
  task automatic tap_reset();
    repeat (5) tck_bit(1'b1, 1'b0);
    tck_bit(1'b0, 1'b0);
  endtask
  // From idle: select, capture, shift LSB first, exit, update, idle
  task automatic shift(input logic is_ir, input logic [31:0] v, input int n);
    tck_bit(1'b1, 1'b0);
    if (is_ir) tck_bit(1'b1, 1'b0);
    tck_bit(1'b0, 1'b0);
    tck_bit(1'b0, 1'b0);
    for (int i = 0; i < n; i++) tck_bit(i == n - 1, v[i]);
    tck_bit(1'b1, 1'b0);
    tck_bit(1'b0, 1'b0);
  endtask
endmodule  // jtag_prog_model

// ===== verif/tb_cfg_integrity_jtag_en.sv
// Self-checking bench with a programmer model.
// Assumes the flash array is reachable as i_dut.u_flash.mem.
`timescale 1ns/1ps
module tb_cfg_integrity_jtag_en;
  localparam int WDT = 50;
  logic        i_sys_clk, i_rst, i_cmd_vld, i_wp_off, i_erase, i_wr_en, i_param_vld, i_wdt_kick;
  logic        i_fast_pulse, jt_on, tck, tms, tdi, fixed_seen;
  logic [6:0]  i_bus_addr;
  logic [7:0]  i_cmd_code;
  logic [5:0]  i_wr_addr;
  logic [31:0] i_wr_data;
  logic [15:0] i_param_val, i_param_min, i_param_max;
  logic [3:0]  gp_in, i_gpio_i, i_gpio_o, i_gpio_drv, o_gpio_o, o_gpio_oe_n, o_gpio_i;
  logic        o_fast_pulse_pin, o_in_reset, o_fw_run, o_fw_bad, o_cfg_dflt, o_bus_alert_out_n, o_log_bad;
  logic        o_jtag_en, o_clk_slow, o_fault_log_en, o_busy, o_ecc_fixed, o_param_ok, o_param_err;
  logic [7:0]  stat;
  int          miscompares, checks_done;
  assign i_gpio_i = jt_on ? {gp_in[3], tdi, tms, tck} : gp_in;
  assign stat = {o_fw_run, o_fw_bad, o_cfg_dflt, o_bus_alert_out_n, o_log_bad, o_jtag_en, o_clk_slow,
                 o_fast_pulse_pin};
  cfg_integrity_jtag_en #(.WDT_CYCLES(17'h32)) i_dut (
    .i_sys_clk, .i_rst, .i_bus_addr, .i_cmd_vld, .i_cmd_code, .i_wp_off, .i_erase, .i_wr_en, .i_wr_addr,
    .i_wr_data, .i_param_vld, .i_param_val, .i_param_min, .i_param_max, .i_wdt_kick, .i_fast_pulse,
    .i_gpio_i, .i_gpio_o, .i_gpio_drv, .o_gpio_o, .o_gpio_oe_n, .o_gpio_i, .o_fast_pulse_pin, .o_in_reset,
    .o_fw_run, .o_fw_bad, .o_cfg_dflt, .o_bus_alert_out_n, .o_log_bad, .o_jtag_en, .o_clk_slow,
    .o_fault_log_en, .o_busy, .o_ecc_fixed, .o_param_ok, .o_param_err);
  jtag_prog_model i_jtag (.i_sys_clk, .i_tdo(o_gpio_o[3]), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n = 1);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_boot();
    int n = 0;
    fixed_seen = 1'b0;
    do begin
      step();
      n++;
      if (o_ecc_fixed === 1'b1) fixed_seen = 1'b1;
    end while (o_in_reset !== 1'b0 && n < 300);
    chk(o_in_reset, 0);
    step(2);
  endtask
  task automatic soft_rst();
    i_cmd_vld = 1'b1;
    i_cmd_code = 8'hdb;
    step();
    i_cmd_vld = 1'b0;
    step();
    chk(o_in_reset, 1);
    wait_boot();
  endtask
  task automatic unprot();
    i_wp_off = 1'b1;
    step();
    i_wp_off = 1'b0;
    step();
  endtask
  // Gap cycle between words
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    i_wr_en = 1'b1;
    i_wr_addr = a;
    i_wr_data = d;
    step();
    i_wr_en = 1'b0;
    step();
  endtask
  task automatic reflash();
    int n = 0;
    unprot();
    i_erase = 1'b1;
    step();
    i_erase = 1'b0;
    step(10);
    chk(o_busy, 1);
    wr(6'h00, 32'h1234_5678);
    while (o_busy === 1'b1 && n < 100) begin
      step();
      n++;
    end
    chk(i_dut.u_flash.mem[0][31:0], 32'hffff_ffff);
    i_wr_en = 1'b1;
    for (int a = 0; a < 64; a++) begin
      i_wr_addr = a[5:0];
      i_wr_data = (a >= 16 && a < 47) ? 32'h1 : ((a == 47) ? 32'h1f : 32'h0);
      step();
    end
    i_wr_en = 1'b0;
    soft_rst();
  endtask
  // Corrupt a word, reboot, repair
  task automatic t_corrupt(input logic [5:0] a, input logic [31:0] bad, input logic [7:0] exp);
    unprot();
    wr(a, bad);
    chk({o_fault_log_en, stat}, 9'h091);
    soft_rst();
    chk(stat, exp);
    unprot();
    wr(a, (a == 6'h10) ? 32'h1 : 32'h0);
    soft_rst();
    chk(stat, 8'h91);
  endtask
  task automatic t_param();
    logic [15:0] v [4];
    v = '{16'h9, 16'ha, 16'h14, 16'h15};
    i_param_min = 16'ha;
    i_param_max = 16'h14;
    i_param_vld = 1'b1;
    for (int i = 0; i < 4; i++) begin
      i_param_val = v[i];
      step();
      chk({o_param_ok, o_param_err}, (i == 1 || i == 2) ? 2'h2 : 2'h1);
    end
    i_param_vld = 1'b0;
  endtask
  task automatic t_ecc();
    i_dut.u_flash.mem[16][3] ^= 1'b1;
    soft_rst();
    chk({fixed_seen, stat}, 9'h191);
    i_dut.u_flash.mem[16][3] ^= 1'b1;
  endtask
  task automatic t_jtag();
    i_bus_addr = 7'h7e;
    soft_rst();
    chk({stat, o_gpio_i}, 12'h970);
    jt_on = 1'b1;
    i_jtag.tap_reset();
    i_jtag.shift(1'b1, 32'h9, 4);
    chk(i_jtag.cap_bits[29:26], 4'h1);
    i_jtag.shift(1'b0, 32'h30, 6);
    i_jtag.shift(1'b1, 32'h8, 4);
    i_jtag.shift(1'b0, 32'ha5a5_0000, 32);
    step(4);
    chk(i_dut.u_flash.mem[48][31:0], 32'ha5a5_0000);
    jt_on = 1'b0;
    unprot();
    wr(6'h30, 32'h0);
    i_bus_addr = 7'h10;
    soft_rst();
    chk(stat, 8'h91);
  endtask
  task automatic t_wdt();
    int n = 0;
    i_cmd_vld = 1'b1;
    i_cmd_code = 8'hda;
    step();
    i_cmd_vld = 1'b0;
    step(2);
    chk(o_in_reset, 0);
    i_wdt_kick = 1'b0;
    while (o_in_reset !== 1'b1 && n < 200) begin
      step();
      n++;
    end
    chk({n >= WDT, n <= WDT + 4}, 2'h3);
    step();
    chk({o_gpio_oe_n, o_fast_pulse_pin}, 5'h1e);
    i_wdt_kick = 1'b1;
    wait_boot();
    chk(stat, 8'h91);
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {i_rst, i_wdt_kick, i_fast_pulse} = 3'h7;
    {i_cmd_vld, i_wp_off, i_erase, i_wr_en, i_param_vld, jt_on} = 6'h0;
    {i_cmd_code, i_wr_addr, i_wr_data, i_param_val, i_param_min, i_param_max} = 94'h0;
    {i_bus_addr, gp_in, i_gpio_o, i_gpio_drv} = 19'h0800;
    step();
    for (int a = 0; a < 64; a++) i_dut.u_flash.mem[a] = 38'h3f_ffff_ffff;
    step(4);
    i_rst = 1'b0;
    wait_boot();
    chk({o_jtag_en, o_clk_slow, o_cfg_dflt, o_bus_alert_out_n, o_gpio_i}, 8'he0);
    reflash();
    chk({o_fault_log_en, stat}, 9'h191);
    gp_in = 4'ha;
    i_gpio_o = 4'h5;
    i_gpio_drv = 4'h3;
    step(3);
    chk({o_gpio_i, o_gpio_o, o_gpio_oe_n}, 12'ha5c);
    t_param();
    t_ecc();
    t_corrupt(6'h00, 32'h7, 8'h50);
    t_corrupt(6'h10, 32'h5, 8'ha1);
    t_corrupt(6'h3f, 32'h1, 8'h99);
    t_jtag();
    t_wdt();
    print_verdict();
  end
  // Whole run needs well under 30k cycles
  initial begin
    #300_000;
    miscompares++;
    print_verdict();
  end
endmodule  // tb_cfg_integrity_jtag_en
